// ---- design/hbm_pkg.sv ----
package hbm_pkg;

    // ----------------------------------------
    // widths and reset values
    // ----------------------------------------
    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned PROD_W    = 16;
    localparam logic [7:0]  PROD_RST  = 8'h00;
    localparam int unsigned MUL_CYCLES = 1;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic       mul_go;
        logic [7:0] working_register;
        logic [7:0] file_operand;
    } hbm_mul_req_s;

    typedef struct packed {
        logic       wr_high;
        logic       wr_low;
        logic [7:0] wdata;
    } hbm_sw_wr_s;

    typedef struct packed {
        logic [7:0] product_high_byte;
        logic [7:0] product_low_byte;
    } hbm_prod_s;

    typedef struct packed {
        hbm_prod_s  prod;
        logic       done;
    } hbm_state_s;

endpackage : hbm_pkg

// ---- design/hbm_mul8.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// combinational 8x8 unsigned array product
// ----------------------------------------
module hbm_mul8 (
    input  wire logic [7:0]  a,
    input  wire logic [7:0]  b,
    output logic      [15:0] p
);
    function automatic logic [15:0] hbm_umul(input logic [7:0] x, input logic [7:0] y);
        logic [15:0] acc;
        acc = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            if (y[i]) begin
                acc = acc + (16'(x) << i);
            end
        end
        return acc;
    endfunction : hbm_umul

    // full width, no truncation
    assign p = hbm_umul(a, b);
endmodule : hbm_mul8

// ---- design/hbm_byte_multiplier.sv ----
`timescale 1ns/10ps
module hbm_byte_multiplier (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire hbm_pkg::hbm_mul_req_s req,
    input  wire hbm_pkg::hbm_sw_wr_s  sw_wr,
    input  wire logic [7:0]           status_in,
    output logic      [7:0]           status_out,
    output hbm_pkg::hbm_prod_s        prod,
    output logic                      mul_done
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    hbm_pkg::hbm_state_s state_q;
    hbm_pkg::hbm_state_s state_d;
    logic [15:0]         product;
    logic [15:0]         mul_ref;
    logic [15:0]         sign_ref;

    // ----------------------------------------
    // reference arithmetic for the checks
    // ----------------------------------------
    // sign extension to 16 bits keeps the low 16 bits of the signed product exact
    function automatic logic [15:0] hbm_sprod(input logic [7:0] x, input logic [7:0] y);
        return {{8{x[7]}}, x} * {{8{y[7]}}, y};
    endfunction : hbm_sprod

    // zero extension first, so no product bit is lost
    function automatic logic [15:0] hbm_uprod(input logic [7:0] x, input logic [7:0] y);
        return 16'(x) * 16'(y);
    endfunction : hbm_uprod

    assign mul_ref  = hbm_uprod(req.working_register, req.file_operand);
    assign sign_ref = hbm_sprod(req.working_register, req.file_operand);

    // ----------------------------------------
    // array multiplier
    // ----------------------------------------
    hbm_mul8 hbm_mul8_i (
        .a (req.working_register),
        .b (req.file_operand),
        .p (product)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    // multiply beats a same-cycle software write; both bytes land together
    always_comb begin
        state_d      = state_q;
        state_d.done = 1'b0;
        if (req.mul_go) begin
            state_d.prod.product_high_byte = product[15:8];
            state_d.prod.product_low_byte  = product[7:0];
            state_d.done                   = 1'b1;
        end else begin
            if (sw_wr.wr_high) begin
                state_d.prod.product_high_byte = sw_wr.wdata;
            end
            if (sw_wr.wr_low) begin
                state_d.prod.product_low_byte = sw_wr.wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '{prod: '{hbm_pkg::PROD_RST, hbm_pkg::PROD_RST}, done: 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    assign prod       = state_q.prod;
    assign mul_done   = state_q.done;
    // flags pass straight through; multiplier has no flag path
    assign status_out = status_in;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_full_product: assert property (@(posedge clk) disable iff (rst)
        req.mul_go |=> {prod.product_high_byte, prod.product_low_byte}
            == 16'($past(req.working_register)) * 16'($past(req.file_operand)))
        else $error("product differs from operand product");

    chk_high_byte_place: assert property (@(posedge clk) disable iff (rst)
        req.mul_go && req.working_register == 8'hff && req.file_operand == 8'hff
        |=> prod.product_high_byte == 8'hfe && prod.product_low_byte == 8'h01)
        else $error("product bytes misplaced");

    chk_flags_kept: assert property (@(posedge clk) disable iff (rst)
        req.mul_go |-> status_out == status_in)
        else $error("multiply altered flags");

    chk_one_cycle: assert property (@(posedge clk) disable iff (rst)
        req.mul_go |=> mul_done ##1 (mul_done == $past(req.mul_go)))
        else $error("multiply not done in one cycle");

    chk_operand_source: assert property (@(posedge clk) disable iff (rst)
        req.mul_go && req.file_operand == 8'h01
        |=> prod.product_low_byte == $past(req.working_register)
            && prod.product_high_byte == 8'h00)
        else $error("operand not taken from working register");

    chk_sw_write: assert property (@(posedge clk) disable iff (rst)
        !req.mul_go && sw_wr.wr_low |=> prod.product_low_byte == $past(sw_wr.wdata))
        else $error("software write lost");

    chk_hold_idle: assert property (@(posedge clk) disable iff (rst)
        !req.mul_go && !sw_wr.wr_low && !sw_wr.wr_high |=> $stable(prod))
        else $error("product changed with no cause");

    chk_mul_wins: assert property (@(posedge clk) disable iff (rst)
        req.mul_go && sw_wr.wr_high
        |=> prod.product_high_byte == $past(product[15:8]))
        else $error("software write beat multiply");

    // controller subtracts each operand where the other one is negative
    chk_sign_fix: assert property (@(posedge clk) disable iff (rst)
        req.mul_go |=> 8'(prod.product_high_byte
            - ($past(req.file_operand[7]) ? $past(req.working_register) : 8'h00)
            - ($past(req.working_register[7]) ? $past(req.file_operand) : 8'h00))
            == $past(sign_ref[15:8]))
        else $error("signed correction inconsistent");

    // ----------------------------------------
    // product value checks
    // ----------------------------------------
    chk_zero_operand: assert property (@(posedge clk) disable iff (rst)
        req.mul_go && (req.working_register == 8'h00 || req.file_operand == 8'h00)
        |=> prod.product_high_byte == 8'h00 && prod.product_low_byte == 8'h00)
        else $error("zero operand gave nonzero product");

    // both top bits set means the product reaches at least 4000h
    chk_no_trunc: assert property (@(posedge clk) disable iff (rst)
        req.mul_go && req.working_register[7] && req.file_operand[7]
        |=> prod.product_high_byte >= 8'h40)
        else $error("product upper bits lost");

    // ----------------------------------------
    // byte placement checks
    // ----------------------------------------
    chk_high_byte_math: assert property (@(posedge clk) disable iff (rst)
        req.mul_go |=> prod.product_high_byte == $past(mul_ref[15:8]))
        else $error("high byte not upper product bits");

    chk_low_byte_math: assert property (@(posedge clk) disable iff (rst)
        req.mul_go |=> prod.product_low_byte == $past(mul_ref[7:0]))
        else $error("low byte not lower product bits");

    // ----------------------------------------
    // flag checks
    // ----------------------------------------
    // flags are the core's; the multiplier must be invisible to them at all times
    chk_flags_idle: assert property (@(posedge clk) disable iff (rst)
        !req.mul_go |-> status_out == status_in)
        else $error("flags altered while idle");

    // ----------------------------------------
    // timing checks
    // ----------------------------------------
    chk_done_rise: assert property (@(posedge clk) disable iff (rst)
        req.mul_go |=> mul_done)
        else $error("done missing after multiply");

    chk_done_pulse: assert property (@(posedge clk) disable iff (rst)
        !req.mul_go |=> !mul_done)
        else $error("done without multiply");

    // back to back instructions each see their own product
    chk_back_to_back: assert property (@(posedge clk) disable iff (rst)
        req.mul_go ##1 req.mul_go
        |=> {prod.product_high_byte, prod.product_low_byte} == $past(mul_ref))
        else $error("second product late");

    // ----------------------------------------
    // operand source checks
    // ----------------------------------------
    chk_file_source: assert property (@(posedge clk) disable iff (rst)
        req.mul_go && req.working_register == 8'h01
        |=> prod.product_low_byte == $past(req.file_operand)
            && prod.product_high_byte == 8'h00)
        else $error("operand not taken from file register");

    // ----------------------------------------
    // software access checks
    // ----------------------------------------
    chk_high_write: assert property (@(posedge clk) disable iff (rst)
        !req.mul_go && sw_wr.wr_high |=> prod.product_high_byte == $past(sw_wr.wdata))
        else $error("software high write lost");

    chk_low_kept: assert property (@(posedge clk) disable iff (rst)
        !req.mul_go && sw_wr.wr_high && !sw_wr.wr_low |=> $stable(prod.product_low_byte))
        else $error("low byte hit by high write");

    chk_high_kept: assert property (@(posedge clk) disable iff (rst)
        !req.mul_go && sw_wr.wr_low && !sw_wr.wr_high |=> $stable(prod.product_high_byte))
        else $error("high byte hit by low write");

    // the low byte must follow the multiply too, never half a write
    chk_mul_wins_low: assert property (@(posedge clk) disable iff (rst)
        req.mul_go && sw_wr.wr_low |=> prod.product_low_byte == $past(mul_ref[7:0]))
        else $error("software low write beat multiply");
endmodule : hbm_byte_multiplier

// ---- verification/hbm_cpu_model.sv ----
`timescale 1ns/10ps
module hbm_cpu_model (
    input  wire logic               clk,
    input  wire hbm_pkg::hbm_prod_s prod,
    output hbm_pkg::hbm_mul_req_s   req
);
    initial req = '0;
    // go stays up so back-to-back instructions never toggle it twice
    task automatic mul(input logic [7:0] w, f, output logic [15:0] p);
        req = {1'b1, w, f};
        @(posedge clk);
        #10 p = prod;
    endtask : mul
    task automatic rest();
        req.mul_go = 1'b0;
    endtask : rest
    task automatic smul(input logic [7:0] a, b, output logic [15:0] p);
        mul(a, b, p);
        if (b[7]) p[15:8] = p[15:8] - a;
        if (a[7]) p[15:8] = p[15:8] - b;
    endtask : smul
    task automatic mul16(input logic [15:0] a, b, output logic [31:0] r);
        logic [15:0] p;
        mul(a[7:0], b[7:0], p);
        r = {16'h0000, p};
        mul(a[15:8], b[15:8], p);
        r = r + {p, 16'h0000};
        mul(a[7:0], b[15:8], p);
        r = r + {8'h00, p, 8'h00};
        mul(a[15:8], b[7:0], p);
        r = r + {8'h00, p, 8'h00};
    endtask : mul16
endmodule : hbm_cpu_model

// ---- verification/test_hw_byte_multiplier.sv ----
`timescale 1ns/10ps
module test_hw_byte_multiplier;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    hbm_pkg::hbm_mul_req_s req;
    hbm_pkg::hbm_sw_wr_s   sw_wr = '0;
    logic [7:0]            status_in = 8'hc3;
    logic [7:0]            status_out;
    hbm_pkg::hbm_prod_s    prod;
    logic                  mul_done;
    logic [15:0]           p;
    logic [31:0]           r;
    int                    mismatches = 0;
    int                    cmp_count = 0;
    always #50 clk = ~clk;
    hbm_cpu_model hbm_cpu_model_i (.clk(clk), .prod(prod), .req(req));
    hbm_byte_multiplier hbm_byte_multiplier_i (.clk(clk), .rst(rst), .req(req), .sw_wr(sw_wr),
        .status_in(status_in), .status_out(status_out), .prod(prod), .mul_done(mul_done));
    task automatic check(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic step();
        @(posedge clk);
        #10;
    endtask : step
    task automatic t_unsigned();
        logic [7:0] a[4] = '{8'hff, 8'h00, 8'h80, 8'h01};
        logic [7:0] b[4] = '{8'hff, 8'hff, 8'h02, 8'h01};
        for (int i = 0; i < 4; i++) begin
            status_in = a[i] ^ b[i] ^ 8'h3c;
            hbm_cpu_model_i.mul(a[i], b[i], p);
            check("product", p, a[i] * b[i]);
            check("done", mul_done, 1'b1);
            check("status", status_out, a[i] ^ b[i] ^ 8'h3c);
        end
        hbm_cpu_model_i.rest();
        step();
        check("done low", mul_done, 1'b0);
    endtask : t_unsigned
    task automatic t_signed();
        hbm_cpu_model_i.smul(8'hff, 8'h02, p);
        check("signed", p, 32'h0000_fffe);
        hbm_cpu_model_i.smul(8'h80, 8'h80, p);
        check("signed", p, 32'h0000_4000);
        hbm_cpu_model_i.mul16(16'hffff, 16'hffff, r);
        check("wide", r, 32'hfffe_0001);
        hbm_cpu_model_i.rest();
        step();
    endtask : t_signed
    task automatic t_write();
        sw_wr = {1'b0, 1'b1, 8'h5a};
        step();
        sw_wr = {1'b1, 1'b0, 8'ha5};
        step();
        check("sw", prod, 32'h0000_a55a);
        sw_wr = {1'b1, 1'b1, 8'h77};
        hbm_cpu_model_i.mul(8'h10, 8'h10, p);
        sw_wr = '0;
        hbm_cpu_model_i.rest();
        check("mul wins", prod, 32'h0000_0100);
    endtask : t_write
    task automatic t_reset();
        hbm_cpu_model_i.mul(8'h33, 8'h03, p);
        check("pre reset", p, 32'h0000_0099);
        hbm_cpu_model_i.rest();
        rst = 1'b1;
        step();
        check("mid reset", {prod, mul_done}, 32'h0000_0000);
        check("reset flags", status_out, status_in);
        rst = 1'b0;
        hbm_cpu_model_i.mul(8'h0f, 8'h11, p);
        check("post reset", p, 32'h0000_00ff);
        hbm_cpu_model_i.rest();
        step();
    endtask : t_reset
    initial begin
        repeat (2) @(posedge clk);
        #10 rst = 1'b0;
        check("reset", {prod, mul_done}, 32'h0000_0000);
        t_unsigned();
        t_signed();
        t_write();
        t_reset();
        close_out();
    end
    initial begin
        #200_000;
        mismatches++;
        close_out();
    end
endmodule : test_hw_byte_multiplier
